// >>> rxp_regs.svh
`ifndef RXP_REGS_SVH
`define RXP_REGS_SVH
`define RXP_DAW 9
`define RXP_SAW 4
`define RXP_SDEP 16
`define RXP_WCW 11
`define RXP_A_DATA 8'h00
`define RXP_A_STAT 8'h04
`define RXP_A_INFO 8'h08
`define RXP_A_CFG 8'h0c
`define RXP_A_DPC 8'h10
`define RXP_A_TXCFG 8'h14
`define RXP_A_ERR 8'h18
`define RXP_A_MACCR 8'h1c
`define RXP_INFO_DU 15:0
`define RXP_INFO_SU 23:16
`define RXP_CFG_PAD 1:0
`define RXP_CFG_OFS 12:8
`define RXP_CFG_DUMP 15
`define RXP_DPC_SKIP 31
`define RXP_TX_STOP 0
`define RXP_TX_ON 1
`define RXP_ERR_RXE 0
`define RXP_ERR_RXH 1
`define RXP_MAC_RECEIVE_ENABLE_BIT 0
`define RXP_LN0 0
`define RXP_LN1 1
`define RXP_LN3 3
`endif

// >>> rxp_pkg.sv
`include "rxp_regs.svh"
package rxp_pkg;
  typedef enum logic [2:0] {
    RXP_IDLE = 3'h0,
    RXP_OFS = 3'h1,
    RXP_DATA = 3'h3,
    RXP_PAD = 3'h2,
    RXP_STAT = 3'h6
  } rxp_wst_t;
  typedef enum logic [1:0] {RXP_SRC_REG = 2'h0, RXP_SRC_DAT = 2'h1, RXP_SRC_STS = 2'h2} rxp_src_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rxp_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } rxp_wb_rsp_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
    logic [31:0] status;
  } rxp_rxb_t;
  typedef struct packed {
    rxp_wst_t st;
    logic [1:0] lane;
    logic [2:0] ocnt;
    logic [`RXP_WCW-1:0] wcnt;
    logic [31:0] acc;
    logic [31:0] stat;
    logic [`RXP_DAW:0] dwp;
    logic [`RXP_DAW:0] drp;
    logic [`RXP_SAW:0] swp;
    logic [`RXP_SAW:0] srp;
    logic [`RXP_SAW:0] bwp;
    logic [`RXP_SAW:0] brp;
    logic [`RXP_SDEP-1:0][`RXP_DAW:0] bnd;
    logic busy;
    logic ack;
    rxp_src_t src;
    logic [31:0] rdat;
    logic [31:0] dat;
    logic [4:0] ofs;
    logic [1:0] pad;
    logic dump;
    logic skip;
    logic err;
    logic receive_enable_bit;
    logic rxact;
    logic rxh;
  } rxp_top_st_t;
  typedef struct packed {
    logic stop;
    logic on;
    logic irq;
  } rxp_tx_st_t;
endpackage : rxp_pkg

// >>> rxp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rxp_mem #(
  parameter int W = 32,
  parameter int AW = 9
) (
  // clock
  input wire logic core_clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port, data one edge after re
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_q
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  // no reset: the owner never reads a word it has not written
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule : rxp_mem
`default_nettype wire

// >>> rxp_txstop.sv
`timescale 1ns/1ps
`default_nettype none
module rxp_txstop (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register write strobe and bits
  input wire logic wr,
  input wire logic wr_stop,
  input wire logic wr_on,
  // transmitter state
  input wire logic tx_in_frame,
  input wire logic tx_status_done,
  // control and event
  output logic tx_stop,
  output logic tx_on,
  output logic tx_run,
  output logic tx_halted_irq
);
  import rxp_pkg::*;
  rxp_tx_st_t q, n;

  always_comb begin
    n = q;
    n.irq = 1'b0;
    // idle, or status of the last frame just came back
    if (q.stop && (!tx_in_frame || tx_status_done)) begin
      n.stop = 1'b0;
      n.on = 1'b0;
      n.irq = 1'b1;
    end
    // both bits set-only; a write lands after the halt so it is not lost
    if (wr) begin
      if (wr_stop) begin
        n.stop = 1'b1;
      end
      if (wr_on) begin
        n.on = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tx_stop = q.stop;
  assign tx_on = q.on;
  assign tx_run = q.on && !q.stop;
  assign tx_halted_irq = q.irq;

  chk_halt_pulse_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.stop && !tx_in_frame && !wr) |=> (tx_halted_irq && !tx_stop && !tx_on) ##1 !tx_halted_irq)
    else $error("tx halt did not pulse and clear");
  chk_hold_in_frame: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.stop && tx_in_frame && !tx_status_done) |=> tx_stop && !tx_halted_irq && !tx_run)
    else $error("tx stop released mid frame");
endmodule : rxp_txstop
`default_nettype wire

// >>> rxp_top.sv
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rxp_regs.svh"
module rxp_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire rxp_pkg::rxp_wb_req_t wb_req,
  output var rxp_pkg::rxp_wb_rsp_t wb_rsp,
  // received bytes from the mac
  input wire rxp_pkg::rxp_rxb_t rx_in,
  output logic rx_ready,
  // transmitter handshake
  input wire logic tx_in_frame,
  input wire logic tx_status_done,
  output logic tx_run,
  // events
  output logic tx_halted_irq,
  output logic rx_halted_irq,
  output logic receiver_error_flag
);
  import rxp_pkg::*;

  rxp_top_st_t q, n;
  logic req, txw, tx_stop, tx_on;
  logic dwe, dre, swe, sre;
  logic [31:0] dwd, drd, srd;
  logic [`RXP_DAW:0] d_used;
  logic [`RXP_SAW:0] s_used, b_used;
  logic d_full, s_full, b_full;

  function automatic logic rxp_pad_due(input logic [`RXP_WCW-1:0] wc, input logic [1:0] pad);
    logic [3:0] m;
    m = 4'h0;
    unique case (pad)
      2'h0: m = 4'h0;
      2'h1: m = 4'h3;
      2'h2: m = 4'h7;
      2'h3: m = 4'hf;
    endcase
    return (wc[3:0] & m) != 4'h0;
  endfunction : rxp_pad_due

  assign d_used = q.dwp - q.drp;
  assign s_used = q.swp - q.srp;
  assign b_used = q.bwp - q.brp;
  assign d_full = d_used[`RXP_DAW];
  assign s_full = s_used[`RXP_SAW];
  assign b_full = b_used[`RXP_SAW];
  assign req = wb_req.cyc && wb_req.stb && !q.busy && !q.ack;
  assign txw = req && wb_req.we && wb_req.adr == `RXP_A_TXCFG && wb_req.sel[`RXP_LN0];

  always_comb begin
    logic [31:0] word;
    word = '0;
    n = q;
    n.rxh = 1'b0;
    n.ack = 1'b0;
    dwe = 1'b0;
    dwd = '0;
    dre = 1'b0;
    swe = 1'b0;
    sre = 1'b0;
    rx_ready = 1'b0;

    // bus side: answer lands two edges after the request is seen
    if (q.busy) begin
      n.busy = 1'b0;
      n.ack = 1'b1;
      unique case (q.src)
        RXP_SRC_DAT: n.dat = drd;
        RXP_SRC_STS: n.dat = srd;
        default: n.dat = q.rdat;
      endcase
    end
    if (req) begin
      n.busy = 1'b1;
      n.src = RXP_SRC_REG;
      n.rdat = '0;
      if (wb_req.we) begin
        unique case (wb_req.adr)
          `RXP_A_CFG: begin
            if (wb_req.sel[`RXP_LN0]) begin
              n.pad = wb_req.dat[`RXP_CFG_PAD];
            end
            if (wb_req.sel[`RXP_LN1]) begin
              n.ofs = wb_req.dat[`RXP_CFG_OFS];
              n.dump = wb_req.dat[`RXP_CFG_DUMP];
            end
          end
          `RXP_A_DPC: begin
            if (wb_req.sel[`RXP_LN3]) begin
              n.skip = wb_req.dat[`RXP_DPC_SKIP];
            end
          end
          `RXP_A_ERR: begin
            // write one to clear; a set later in this process still wins
            if (wb_req.sel[`RXP_LN0] && wb_req.dat[`RXP_ERR_RXE]) begin
              n.err = 1'b0;
            end
          end
          `RXP_A_MACCR: begin
            if (wb_req.sel[`RXP_LN0]) begin
              n.receive_enable_bit = wb_req.dat[`RXP_MAC_RECEIVE_ENABLE_BIT];
            end
          end
          default: n.rdat = '0;
        endcase
      end else begin
        unique case (wb_req.adr)
          `RXP_A_DATA: begin
            if (d_used == '0) begin
              n.err = 1'b1;
            end else begin
              dre = 1'b1;
              n.src = RXP_SRC_DAT;
              n.drp = q.drp + 1'b1;
              // crossing a packet end retires its boundary mark
              if (b_used != '0 && q.drp + 1'b1 == q.bnd[q.brp[`RXP_SAW-1:0]]) begin
                n.brp = q.brp + 1'b1;
              end
            end
          end
          `RXP_A_STAT: begin
            if (s_used == '0) begin
              n.err = 1'b1;
            end else begin
              sre = 1'b1;
              n.src = RXP_SRC_STS;
              n.srp = q.srp + 1'b1;
            end
          end
          `RXP_A_INFO: begin
            n.rdat[`RXP_INFO_DU] = 16'(d_used);
            n.rdat[`RXP_INFO_SU] = 8'(s_used);
          end
          `RXP_A_CFG: begin
            n.rdat[`RXP_CFG_PAD] = q.pad;
            n.rdat[`RXP_CFG_OFS] = q.ofs;
            n.rdat[`RXP_CFG_DUMP] = q.dump;
          end
          `RXP_A_DPC: n.rdat[`RXP_DPC_SKIP] = q.skip;
          `RXP_A_TXCFG: begin
            n.rdat[`RXP_TX_STOP] = tx_stop;
            n.rdat[`RXP_TX_ON] = tx_on;
          end
          `RXP_A_ERR: begin
            n.rdat[`RXP_ERR_RXE] = q.err;
            n.rdat[`RXP_ERR_RXH] = !q.rxact;
          end
          `RXP_A_MACCR: n.rdat[`RXP_MAC_RECEIVE_ENABLE_BIT] = q.receive_enable_bit;
          default: n.rdat = '0;
        endcase
      end
    end

    // receive writer: offset words, data, padding, then status
    unique case (q.st)
      RXP_IDLE: begin
        if (q.receive_enable_bit && rx_in.valid && !q.dump) begin
          n.lane = q.ofs[1:0];
          n.ocnt = q.ofs[4:2];
          n.wcnt = '0;
          n.acc = '0;
          n.st = (q.ofs[4:2] != 3'h0) ? RXP_OFS : RXP_DATA;
        end
      end
      RXP_OFS: begin
        if (!d_full) begin
          dwe = 1'b1;
          n.wcnt = q.wcnt + 1'b1;
          n.ocnt = q.ocnt - 1'b1;
          if (q.ocnt == 3'h1) begin
            n.st = RXP_DATA;
          end
        end
      end
      RXP_DATA: begin
        // stalling the mac is cheaper than losing a byte
        rx_ready = !d_full;
        if (rx_in.valid && !d_full) begin
          word = q.acc;
          word[{q.lane, 3'h0} +: 8] = rx_in.data;
          n.acc = word;
          n.lane = q.lane + 1'b1;
          if (q.lane == 2'h3 || rx_in.last) begin
            dwe = 1'b1;
            dwd = word;
            n.acc = '0;
            n.lane = 2'h0;
            n.wcnt = q.wcnt + 1'b1;
          end
          if (rx_in.last) begin
            n.stat = rx_in.status;
            n.st = rxp_pad_due(q.wcnt + 1'b1, q.pad) ? RXP_PAD : RXP_STAT;
          end
        end
      end
      RXP_PAD: begin
        if (!d_full) begin
          dwe = 1'b1;
          n.wcnt = q.wcnt + 1'b1;
          if (!rxp_pad_due(q.wcnt + 1'b1, q.pad)) begin
            n.st = RXP_STAT;
          end
        end
      end
      RXP_STAT: begin
        if (s_full) begin
          n.err = 1'b1;
        end else begin
          swe = 1'b1;
          n.swp = q.swp + 1'b1;
        end
        if (!b_full) begin
          n.bnd[q.bwp[`RXP_SAW-1:0]] = q.dwp;
          n.bwp = q.bwp + 1'b1;
        end
        n.st = RXP_IDLE;
      end
      default: n.st = RXP_IDLE;
    endcase
    if (dwe) begin
      n.dwp = q.dwp + 1'b1;
    end

    // a packet still being written has no mark yet and is not skipped
    if (q.skip) begin
      if (b_used != '0) begin
        n.drp = q.bnd[q.brp[`RXP_SAW-1:0]];
        n.brp = q.brp + 1'b1;
      end
      n.skip = 1'b0;
    end

    if (q.receive_enable_bit) begin
      n.rxact = 1'b1;
    end else if (q.rxact && q.st == RXP_IDLE) begin
      n.rxact = 1'b0;
      n.rxh = 1'b1;
    end

    if (q.dump) begin
      n.dwp = '0;
      n.drp = '0;
      n.swp = '0;
      n.srp = '0;
      n.bwp = '0;
      n.brp = '0;
      n.st = RXP_IDLE;
      n.dump = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  rxp_mem #(.W(32), .AW(`RXP_DAW)) u_dmem (
    .core_clk(core_clk),
    .we(dwe),
    .waddr(q.dwp[`RXP_DAW-1:0]),
    .wdata(dwd),
    .re(dre),
    .raddr(q.drp[`RXP_DAW-1:0]),
    .rdata_q(drd)
  );

  rxp_mem #(.W(32), .AW(`RXP_SAW)) u_smem (
    .core_clk(core_clk),
    .we(swe),
    .waddr(q.swp[`RXP_SAW-1:0]),
    .wdata(q.stat),
    .re(sre),
    .raddr(q.srp[`RXP_SAW-1:0]),
    .rdata_q(srd)
  );

  rxp_txstop u_tx (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr(txw),
    .wr_stop(wb_req.dat[`RXP_TX_STOP]),
    .wr_on(wb_req.dat[`RXP_TX_ON]),
    .tx_in_frame(tx_in_frame),
    .tx_status_done(tx_status_done),
    .tx_stop(tx_stop),
    .tx_on(tx_on),
    .tx_run(tx_run),
    .tx_halted_irq(tx_halted_irq)
  );

  assign wb_rsp = '{ack: q.ack, dat: q.dat};
  assign rx_halted_irq = q.rxh;
  assign receiver_error_flag = q.err;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_skip_self_clear: assert property (q.skip |=> !q.skip)
    else $error("skip bit did not clear");
  chk_skip_keeps_status: assert property (q.skip && !q.dump |=> $stable(q.srp))
    else $error("skip moved the status fifo");
  chk_dump_pointers: assert property (q.dump |=> q.dwp == '0 && q.drp == '0 && q.swp == '0 && q.srp == '0 && !q.dump)
    else $error("dump left pointers set");
  chk_underrun_err: assert property (req && !wb_req.we && wb_req.adr == `RXP_A_DATA && d_used == '0 |=> receiver_error_flag)
    else $error("data underrun not flagged");
  chk_pad_aligned: assert property (q.st == RXP_STAT |-> !rxp_pad_due(q.wcnt, q.pad))
    else $error("packet not padded to burst");
  chk_status_last: assert property ((q.st == RXP_DATA && rx_in.valid && rx_in.last && rx_ready && q.pad == 2'h0 && !q.dump)
    |=> q.st == RXP_STAT ##1 q.st == RXP_IDLE)
    else $error("status not written right after data");
  chk_rx_halt_pulse: assert property ((!q.receive_enable_bit && q.rxact && q.st == RXP_IDLE) |=> rx_halted_irq ##1 !rx_halted_irq)
    else $error("rx halt pulse missing");
endmodule : rxp_top
`default_nettype wire

// >>> rxp_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxp_mac_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // frame request from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [10:0] len,
  input wire logic [7:0] first_byte,
  // byte stream into the block
  input wire logic rx_ready,
  output var rxp_pkg::rxp_rxb_t rx_in,
  output logic busy
);
  import rxp_pkg::*;
  logic [10:0] idx_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_in <= '0;
      idx_q <= '0;
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      idx_q <= 11'h001;
      rx_in <= '{valid: 1'b1, last: (len == 11'h001), data: first_byte, status: {5'h00, len, 16'h0000}};
    end else if (busy && (!rx_in.valid || rx_ready)) begin
      if (rx_in.valid && (rx_in.last || slow)) begin
        // released line must not keep showing the last byte
        rx_in.valid <= 1'b0;
        rx_in.data <= ~rx_in.data;
        busy <= !rx_in.last;
      end else begin
        rx_in.valid <= 1'b1;
        rx_in.data <= first_byte + idx_q[7:0];
        rx_in.last <= (idx_q + 11'h001 == len);
        idx_q <= idx_q + 11'h001;
      end
    end
  end
endmodule : rxp_mac_model
`default_nettype wire

// >>> tb_rx_fifo_path_tx_stop_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxp_regs.svh"
module tb_rx_fifo_path_tx_stop_ctrl;
  import rxp_pkg::*;
  logic core_clk;
  logic reset_n;
  rxp_wb_req_t wb_req;
  rxp_wb_rsp_t wb_rsp;
  rxp_rxb_t rx_in;
  logic rx_ready, tx_in_frame, tx_status_done, tx_run, tx_halted_irq, rx_halted_irq, receiver_error_flag;
  logic go, slow, mac_busy;
  logic [10:0] len;
  logic [7:0] first_byte;
  logic [31:0] rd;
  int n_errors, checks, tx_cnt, rx_cnt;

  rxp_top u_rxp_top (.core_clk(core_clk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .rx_in(rx_in), .rx_ready(rx_ready), .tx_in_frame(tx_in_frame), .tx_status_done(tx_status_done),
    .tx_run(tx_run), .tx_halted_irq(tx_halted_irq), .rx_halted_irq(rx_halted_irq),
    .receiver_error_flag(receiver_error_flag));
  rxp_mac_model u_rxp_mac_model (.core_clk(core_clk), .reset_n(reset_n), .go(go), .slow(slow), .len(len),
    .first_byte(first_byte), .rx_ready(rx_ready), .rx_in(rx_in), .busy(mac_busy));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // events are single-cycle pulses, so count them rather than poll
  always @(posedge core_clk) begin
    if (tx_halted_irq === 1'b1) tx_cnt++;
    if (rx_halted_irq === 1'b1) rx_cnt++;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    @(posedge core_clk);
    while (wb_rsp.ack !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    rd = wb_rsp.dat;
    if (n >= 20) begin
      chk("wb ack", 32'h0, 32'h1);
      tally_and_finish;
    end
    wb_req <= '0;
    @(posedge core_clk);
  endtask : wb

  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(name, rd, exp);
  endtask : rdchk

  task automatic frame(input logic [10:0] n, input logic [7:0] s, input logic sl);
    int k;
    k = 0;
    len <= n;
    first_byte <= s;
    slow <= sl;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    while (mac_busy === 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 200) begin
      chk("mac done", 32'h0, 32'h1);
      tally_and_finish;
    end
    // writer may still push up to 15 pad words after the mac goes quiet
    repeat (20) @(posedge core_clk);
  endtask : frame

  task automatic t_reset;
    chk("tx_run", 32'(tx_run), 32'h0);
    chk("err flag", 32'(receiver_error_flag), 32'h0);
    chk("ready", 32'(rx_ready), 32'h0);
    rdchk("info", `RXP_A_INFO, 32'h0);
  endtask : t_reset

  task automatic t_basic;
    wb(1'b1, `RXP_A_MACCR, 32'h1);
    frame(11'd5, 8'h10, 1'b0);
    rdchk("info", `RXP_A_INFO, 32'h0001_0002);
    rdchk("status", `RXP_A_STAT, 32'h0005_0000);
    rdchk("data0", `RXP_A_DATA, 32'h1312_1110);
    rdchk("data1", `RXP_A_DATA, 32'h0000_0014);
    chk("no err", 32'(receiver_error_flag), 32'h0);
  endtask : t_basic

  task automatic t_ofs_pad;
    logic [7:0] s;
    // offset 6 bytes, pad to 4 words; changed only between packets
    wb(1'b1, `RXP_A_CFG, 32'h0000_0601);
    frame(11'd3, 8'h20, 1'b0);
    frame(11'd3, 8'h30, 1'b1);
    rdchk("info", `RXP_A_INFO, 32'h0002_0008);
    rdchk("stat a", `RXP_A_STAT, 32'h0003_0000);
    rdchk("stat b", `RXP_A_STAT, 32'h0003_0000);
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 8'h20 : 8'h30;
      rdchk("ofs word", `RXP_A_DATA, 32'h0);
      rdchk("lanes", `RXP_A_DATA, {s + 8'h01, s, 16'h0000});
      rdchk("tail", `RXP_A_DATA, {24'h0, s + 8'h02});
      // pad word content is zero, host discards it
      wb(1'b0, `RXP_A_DATA, 32'h0);
    end
    rdchk("drained", `RXP_A_INFO, 32'h0);
    chk("no err", 32'(receiver_error_flag), 32'h0);
    wb(1'b1, `RXP_A_CFG, 32'h0);
  endtask : t_ofs_pad

  task automatic t_underrun;
    rdchk("empty data", `RXP_A_DATA, 32'h0);
    chk("flag data", 32'(receiver_error_flag), 32'h1);
    wb(1'b1, `RXP_A_ERR, 32'h1);
    chk("flag clr", 32'(receiver_error_flag), 32'h0);
    rdchk("empty stat", `RXP_A_STAT, 32'h0);
    chk("flag stat", 32'(receiver_error_flag), 32'h1);
    // pulsing reset_n resynchronises the host after an underrun
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("flag reset", 32'(receiver_error_flag), 32'h0);
    wb(1'b1, `RXP_A_MACCR, 32'h1);
  endtask : t_underrun

  task automatic t_skip;
    // pad to 8 words, so the skip has to jump past the filler too
    wb(1'b1, `RXP_A_CFG, 32'h0000_0002);
    frame(11'd16, 8'h50, 1'b0);
    frame(11'd4, 8'h40, 1'b0);
    rdchk("info", `RXP_A_INFO, 32'h0002_0010);
    // head packet is eight words with its padding; no fifo reads while pending
    wb(1'b1, `RXP_A_DPC, 32'h8000_0000);
    repeat (4) @(posedge core_clk);
    rdchk("skip clr", `RXP_A_DPC, 32'h0);
    rdchk("info", `RXP_A_INFO, 32'h0002_0008);
    rdchk("stat a", `RXP_A_STAT, 32'h0010_0000);
    rdchk("stat b", `RXP_A_STAT, 32'h0004_0000);
    rdchk("next pkt", `RXP_A_DATA, 32'h4342_4140);
  endtask : t_skip

  task automatic t_dump;
    int k;
    frame(11'd5, 8'h60, 1'b0);
    k = rx_cnt;
    wb(1'b1, `RXP_A_MACCR, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("rx halt pulse", 32'(rx_cnt - k), 32'h1);
    rdchk("halted", `RXP_A_ERR, 32'h2);
    // dump together with pad to 16 words for the refill
    wb(1'b1, `RXP_A_CFG, 32'h0000_8003);
    rdchk("dump clr", `RXP_A_CFG, 32'h3);
    rdchk("flushed", `RXP_A_INFO, 32'h0);
    wb(1'b1, `RXP_A_MACCR, 32'h1);
    frame(11'd4, 8'h70, 1'b1);
    rdchk("refill", `RXP_A_INFO, 32'h0001_0010);
    rdchk("stat", `RXP_A_STAT, 32'h0004_0000);
    rdchk("data", `RXP_A_DATA, 32'h7372_7170);
  endtask : t_dump

  task automatic t_tx;
    int k;
    wb(1'b1, `RXP_A_TXCFG, 32'h2);
    chk("run on", 32'(tx_run), 32'h1);
    tx_in_frame <= 1'b1;
    k = tx_cnt;
    wb(1'b1, `RXP_A_TXCFG, 32'h1);
    repeat (5) @(posedge core_clk);
    chk("run off", 32'(tx_run), 32'h0);
    chk("in flight", 32'(tx_cnt - k), 32'h0);
    rdchk("bits held", `RXP_A_TXCFG, 32'h3);
    tx_status_done <= 1'b1;
    tx_in_frame <= 1'b0;
    @(posedge core_clk);
    tx_status_done <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("one pulse", 32'(tx_cnt - k), 32'h1);
    rdchk("bits clr", `RXP_A_TXCFG, 32'h0);
    wb(1'b1, `RXP_A_TXCFG, 32'h2);
    chk("resume", 32'(tx_run), 32'h1);
    k = tx_cnt;
    wb(1'b1, `RXP_A_TXCFG, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("idle stop", 32'(tx_cnt - k), 32'h1);
  endtask : t_tx

  task automatic tally_and_finish;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    reset_n = 1'b0;
    wb_req = '0;
    tx_in_frame = 1'b0;
    tx_status_done = 1'b0;
    go = 1'b0;
    slow = 1'b0;
    len = 11'h0;
    first_byte = 8'h0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset;
    t_basic;
    t_ofs_pad;
    t_underrun;
    t_skip;
    t_dump;
    t_tx;
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish;
  end
endmodule : tb_rx_fifo_path_tx_stop_ctrl
`default_nettype wire
